// ==== logic/pscfg_pkg.sv ====
`default_nettype none

package pscfg_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int NUM_EV = 6;

  // Register offsets on the plain register port
  localparam logic [ADDR_W-1:0] OFS_STATUS = 10'h01F;
  localparam logic [ADDR_W-1:0] OFS_DRV0 = 10'h0F0;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 10'h100;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 10'h101;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 10'h102;

  // Driver control field positions
  localparam int DRV_FMT = 7;
  localparam int DRV_LEG_B = 6;
  localparam int DRV_LEG_A = 5;
  localparam int DRV_POL_HI = 4;
  localparam int DRV_POL_LO = 3;

  // Interrupt event positions
  localparam int EV_LOCK_GAIN = 0;
  localparam int EV_LOCK_LOSS = 1;
  localparam int EV_HOLD_IN = 2;
  localparam int EV_HOLD_OUT = 3;
  localparam int EV_REF_SWAP = 4;
  localparam int EV_FREQ_CHG = 5;

  // Values after reset
  localparam logic [DATA_W-1:0] DRV0_RST = 8'h62;
  localparam logic [NUM_EV-1:0] IRQ_EN_RST = 6'h00;
  localparam logic [NUM_EV-1:0] IRQ_STAT_RST = 6'h00;
  localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;
  localparam logic [1:0] ARM_CYCLES = 2'h3;

  // Live status, packed in status register bit order 5..0
  typedef struct packed {
    logic holdover;
    logic second_reference_input_sel;
    logic vco_above;
    logic second_reference_input_above;
    logic first_reference_input_above;
    logic locked;
  } pscfg_status_s;

  // Leg controls handed to the analog output driver
  typedef struct packed {
    logic cmos_mode;
    logic a_en;
    logic b_en;
    logic a_inv;
    logic b_inv;
  } pscfg_leg_s;

  // One register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } pscfg_bus_s;

  // Legs decoded from the driver reset byte: LVDS, both on, A noninverting
  localparam pscfg_leg_s LEG_RST = 5'h0D;

  // Address match, shared by the write and read decoders
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

endpackage

`default_nettype wire

// ==== logic/pscfg_sync.sv ====
`timescale 1ns/1ns
`default_nettype none

// Two-stage synchroniser for the analog status levels
module pscfg_sync #(
  parameter int WIDTH = 6
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second; nothing else may look at it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ==== logic/pscfg_drv.sv ====
`timescale 1ns/1ns
`default_nettype none

// Decodes the driver control byte into per-leg controls
module pscfg_drv (
  input wire logic [pscfg_pkg::DATA_W-1:0] cfg,
  output pscfg_pkg::pscfg_leg_s leg
);

  logic pol_lo;
  logic pol_hi;

  assign pol_lo = cfg[pscfg_pkg::DRV_POL_LO];
  assign pol_hi = cfg[pscfg_pkg::DRV_POL_HI];

  // LVDS drives both legs as a pair; CMOS drives legs separately
  always_comb begin
    leg = '0;
    leg.cmos_mode = cfg[pscfg_pkg::DRV_FMT];
    if (cfg[pscfg_pkg::DRV_FMT]) begin
      leg.a_en = cfg[pscfg_pkg::DRV_LEG_A];
      leg.b_en = cfg[pscfg_pkg::DRV_LEG_B];
      leg.a_inv = pol_lo;
      leg.b_inv = pol_hi ^ pol_lo;
    end else begin
      // Upper polarity bit is ignored here
      leg.a_en = 1'b1;
      leg.b_en = 1'b1;
      leg.a_inv = pol_lo;
      leg.b_inv = ~pol_lo;
    end
  end

endmodule

`default_nettype wire

// ==== logic/pscfg_top.sv ====
`timescale 1ns/1ns
`default_nettype none

// PLL readback status and first output driver control registers
module pscfg_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire pscfg_pkg::pscfg_bus_s bus,
  output logic [pscfg_pkg::DATA_W-1:0] rd_data_q,
  input wire logic holdover_active,
  input wire logic second_reference_input_selected,
  input wire logic vco_above_thresh,
  input wire logic second_reference_input_above_thresh,
  input wire logic first_reference_input_above_thresh,
  input wire logic lock_detect,
  output pscfg_pkg::pscfg_leg_s leg_q,
  output logic irq_q
);

  // Status capture
  // Analog levels move with no relation to clk, so they pass two
  // flip-flops before any logic reads them

  pscfg_pkg::pscfg_status_s raw_status;
  pscfg_pkg::pscfg_status_s live_status;
  pscfg_pkg::pscfg_status_s prev_q;
  pscfg_pkg::pscfg_status_s prev_d;

  // Pack the analog levels in readback bit order
  always_comb begin
    raw_status = '0;
    raw_status.holdover = holdover_active;
    raw_status.second_reference_input_sel = second_reference_input_selected;
    raw_status.vco_above = vco_above_thresh;
    raw_status.second_reference_input_above = second_reference_input_above_thresh;
    raw_status.first_reference_input_above = first_reference_input_above_thresh;
    raw_status.locked = lock_detect;
  end

  // Levels come from the analog core, outside this clock's domain
  pscfg_sync #(
    .WIDTH($bits(pscfg_pkg::pscfg_status_s))
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(raw_status),
    .sync_out(live_status)
  );

  // Write decode
  // The status word has no write strobe at all, which keeps
  // software from disturbing a live readback

  logic wr_drv0;
  logic wr_irq_clr;
  logic wr_irq_en;
  logic rd_any;

  // Status and event status are read-only; writes there fall away
  always_comb begin
    wr_drv0 = bus.wr & pscfg_pkg::hit(bus.addr, pscfg_pkg::OFS_DRV0);
    wr_irq_clr = bus.wr & pscfg_pkg::hit(bus.addr, pscfg_pkg::OFS_IRQ_CLR);
    wr_irq_en = bus.wr & pscfg_pkg::hit(bus.addr, pscfg_pkg::OFS_IRQ_EN);
    rd_any = bus.rd;
  end

  // Driver control register
  // Only bits 7:3 shape the legs; the low bits are kept so that
  // software reads back exactly what it wrote

  logic [pscfg_pkg::DATA_W-1:0] drv0_q;
  logic [pscfg_pkg::DATA_W-1:0] drv0_d;
  pscfg_pkg::pscfg_leg_s leg_next;

  // All eight bits are stored so readback returns what was written
  always_comb begin
    drv0_d = drv0_q;
    if (wr_drv0) begin
      drv0_d = bus.wdata;
    end
  end

  // Decode from the next value so the legs move on the write edge
  pscfg_drv u_drv (
    .cfg(drv0_d),
    .leg(leg_next)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      drv0_q <= pscfg_pkg::DRV0_RST;
      leg_q <= pscfg_pkg::LEG_RST;
    end else begin
      drv0_q <= drv0_d;
      leg_q <= leg_next;
    end
  end

  // Event detection
  // Each event is a change of one synchronised level (any of three
  // for the frequency event), found by comparing it with its value one cycle earlier

  logic [1:0] arm_q;
  logic [1:0] arm_d;
  logic armed;
  logic [pscfg_pkg::NUM_EV-1:0] ev;

  // Events stay quiet until the synchroniser and history have filled,
  // otherwise a status already high at reset would raise false edges
  always_comb begin
    arm_d = arm_q;
    if (arm_q != pscfg_pkg::ARM_CYCLES) begin
      arm_d = arm_q + 2'h1;
    end
    armed = (arm_q == pscfg_pkg::ARM_CYCLES);
    prev_d = live_status;
  end

  // Edges of the live status become one-cycle events
  always_comb begin
    ev = '0;
    if (armed) begin
      ev[pscfg_pkg::EV_LOCK_GAIN] = live_status.locked & ~prev_q.locked;
      ev[pscfg_pkg::EV_LOCK_LOSS] = ~live_status.locked & prev_q.locked;
      ev[pscfg_pkg::EV_HOLD_IN] = live_status.holdover & ~prev_q.holdover;
      ev[pscfg_pkg::EV_HOLD_OUT] = ~live_status.holdover & prev_q.holdover;
      ev[pscfg_pkg::EV_REF_SWAP] = live_status.second_reference_input_sel ^ prev_q.second_reference_input_sel;
      ev[pscfg_pkg::EV_FREQ_CHG] =
        (live_status.vco_above ^ prev_q.vco_above) |
        (live_status.second_reference_input_above ^ prev_q.second_reference_input_above) |
        (live_status.first_reference_input_above ^ prev_q.first_reference_input_above);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      arm_q <= 2'h0;
      prev_q <= '0;
    end else begin
      arm_q <= arm_d;
      prev_q <= prev_d;
    end
  end

  // Interrupt registers
  // Sticky event bits, an enable mask and one level output
  // taken straight from a flip-flop

  logic [pscfg_pkg::NUM_EV-1:0] irq_stat_q;
  logic [pscfg_pkg::NUM_EV-1:0] irq_stat_d;
  logic [pscfg_pkg::NUM_EV-1:0] irq_en_q;
  logic [pscfg_pkg::NUM_EV-1:0] irq_en_d;
  logic [pscfg_pkg::NUM_EV-1:0] clr_mask;
  logic irq_d;

  // Clear first, then set, so an event in the clear cycle survives
  always_comb begin
    clr_mask = '0;
    if (wr_irq_clr) begin
      clr_mask = bus.wdata[pscfg_pkg::NUM_EV-1:0];
    end
    irq_stat_d = (irq_stat_q & ~clr_mask) | ev;
    irq_en_d = irq_en_q;
    if (wr_irq_en) begin
      irq_en_d = bus.wdata[pscfg_pkg::NUM_EV-1:0];
    end
    irq_d = |(irq_stat_d & irq_en_d);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_q <= pscfg_pkg::IRQ_STAT_RST;
      irq_en_q <= pscfg_pkg::IRQ_EN_RST;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_en_q <= irq_en_d;
      irq_q <= irq_d;
    end
  end

  // Read path
  // One read strobe in, one cycle of data out; the data return
  // to zero so a stale value never looks fresh

  logic [pscfg_pkg::DATA_W-1:0] rd_data_d;
  logic [pscfg_pkg::DATA_W-1:0] status_word;

  // Status word is the synchronised live level, never a stored copy
  always_comb begin
    status_word = '0;
    status_word[5] = live_status.holdover;
    status_word[4] = live_status.second_reference_input_sel;
    status_word[3] = live_status.vco_above;
    status_word[2] = live_status.second_reference_input_above;
    status_word[1] = live_status.first_reference_input_above;
    status_word[0] = live_status.locked;
  end

  // Unmapped and write-only addresses read as zero
  always_comb begin
    rd_data_d = '0;
    if (rd_any) begin
      if (pscfg_pkg::hit(bus.addr, pscfg_pkg::OFS_STATUS)) begin
        rd_data_d = status_word;
      end else if (pscfg_pkg::hit(bus.addr, pscfg_pkg::OFS_DRV0)) begin
        rd_data_d = drv0_q;
      end else if (pscfg_pkg::hit(bus.addr, pscfg_pkg::OFS_IRQ_STAT)) begin
        rd_data_d = {2'h0, irq_stat_q};
      end else if (pscfg_pkg::hit(bus.addr, pscfg_pkg::OFS_IRQ_EN)) begin
        rd_data_d = {2'h0, irq_en_q};
      end else begin
        rd_data_d = '0;
      end
    end
  end

  // Data stand for exactly the cycle after the read strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_q <= pscfg_pkg::RDATA_RST;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

endmodule

`default_nettype wire

// ==== verification/pscfg_chk.sv ====
`timescale 1ns/1ns
`default_nettype none

// Port-level checks for the status readback and driver control registers
module pscfg_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire pscfg_pkg::pscfg_bus_s bus,
  input wire logic [pscfg_pkg::DATA_W-1:0] rd_data_q,
  input wire logic holdover_active,
  input wire logic second_reference_input_selected,
  input wire logic vco_above_thresh,
  input wire logic second_reference_input_above_thresh,
  input wire logic first_reference_input_above_thresh,
  input wire logic lock_detect,
  input wire pscfg_pkg::pscfg_leg_s leg_q,
  input wire logic irq_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [5:0] st;
  logic [5:0] st_q;
  logic [1:0] stab_q;
  logic [1:0] stab_d;
  assign st = {holdover_active, second_reference_input_selected, vco_above_thresh,
               second_reference_input_above_thresh, first_reference_input_above_thresh, lock_detect};
  // Inputs must hold still past the synchroniser before a read is judged
  always_comb begin
    stab_d = (st != st_q) ? 2'h0 : ((stab_q == 2'h3) ? stab_q : stab_q + 2'h1);
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= 6'h00;
      stab_q <= 2'h0;
    end else begin
      st_q <= st;
      stab_q <= stab_d;
    end
  end
  // Leg controls expected from a control byte
  function automatic logic [4:0] dec(input logic [7:0] c);
    dec = c[7] ? {1'h1, c[5], c[6], c[3], c[4] ^ c[3]} : {1'h0, 1'h1, 1'h1, c[3], ~c[3]};
  endfunction
  property p_st_rd;
    bus.rd && bus.addr == pscfg_pkg::OFS_STATUS && stab_q == 2'h3 && st == st_q
      |=> rd_data_q == {2'h0, $past(st)};
  endproperty
  a_st_rd: assert property (p_st_rd)
    else $error("status readback wrong");
  property p_rd_idle;
    !bus.rd |=> rd_data_q == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");
  property p_leg_dec;
    bus.wr && bus.addr == pscfg_pkg::OFS_DRV0 |=> leg_q == dec($past(bus.wdata));
  endproperty
  a_leg_dec: assert property (p_leg_dec)
    else $error("leg decode wrong");
  property p_leg_hold;
    !(bus.wr && bus.addr == pscfg_pkg::OFS_DRV0) |=> $stable(leg_q);
  endproperty
  a_leg_hold: assert property (p_leg_hold)
    else $error("legs changed without a write");
  property p_drv_rb;
    bus.wr && bus.addr == pscfg_pkg::OFS_DRV0 ##1 bus.rd && bus.addr == pscfg_pkg::OFS_DRV0
      |=> rd_data_q == $past(bus.wdata, 2);
  endproperty
  a_drv_rb: assert property (p_drv_rb)
    else $error("driver control readback wrong");
  property p_unmap;
    bus.rd && (bus.addr == pscfg_pkg::OFS_IRQ_CLR || bus.addr > pscfg_pkg::OFS_IRQ_EN)
      |=> rd_data_q == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unreadable address gave data");
  property p_irq_top;
    bus.rd && bus.addr == pscfg_pkg::OFS_IRQ_STAT |=> rd_data_q[7:6] == 2'h0;
  endproperty
  a_irq_top: assert property (p_irq_top)
    else $error("event status top bits set");
  property p_irq_mask;
    bus.wr && bus.addr == pscfg_pkg::OFS_IRQ_EN && bus.wdata[5:0] == 6'h00 |=> !irq_q;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt high with all events masked");
endmodule

`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  pscfg_pkg::pscfg_bus_s bus = '0;
  logic [5:0] st = 6'h00;
  logic [pscfg_pkg::DATA_W-1:0] rd_data_q;
  pscfg_pkg::pscfg_leg_s leg_q;
  logic irq_q;
  logic [7:0] d;
  int n_fail = 0;
  int compares = 0;
  // Free-running 125 MHz clock
  initial begin
    forever #4 clk = ~clk;
  end
  pscfg_top u_pscfg_top (.clk(clk), .arst_n(arst_n), .bus(bus), .rd_data_q(rd_data_q),
    .holdover_active(st[5]), .second_reference_input_selected(st[4]), .vco_above_thresh(st[3]),
    .second_reference_input_above_thresh(st[2]), .first_reference_input_above_thresh(st[1]), .lock_detect(st[0]),
    .leg_q(leg_q), .irq_q(irq_q));
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Single-cycle register strobes; return just after the taking edge
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= {a, v, 1'h1, 1'h0};
    @(posedge clk);
    bus <= '0;
    #1;
  endtask
  // Write then read back with no idle cycle between the strobes
  task automatic wr_rd(input logic [9:0] a, input logic [7:0] v, output logic [7:0] r);
    @(posedge clk);
    bus <= {a, v, 1'h1, 1'h0};
    @(posedge clk);
    bus <= {a, 8'h00, 1'h0, 1'h1};
    @(posedge clk);
    bus <= '0;
    #1 r = rd_data_q;
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= {a, 8'h00, 1'h0, 1'h1};
    @(posedge clk);
    bus <= '0;
    #1 v = rd_data_q;
  endtask
  // Expected leg controls, worked out independently of the design
  function automatic logic [7:0] dec(input logic [7:0] c);
    dec = c[7] ? {4'h1, c[5], c[6], c[3], c[4] ^ c[3]} : {4'h0, 1'h1, c[3], ~c[3]};
    dec[4] = 1'h0;
    dec[7:5] = 3'h0;
    dec[4:0] = c[7] ? {1'h1, c[5], c[6], c[3], c[4] ^ c[3]} : {3'h3, c[3], ~c[3]};
  endfunction
  task automatic t_reset();
    chk("leg", {3'h0, leg_q}, dec(pscfg_pkg::DRV0_RST));
    rd(pscfg_pkg::OFS_DRV0, d);
    chk("drv", d, pscfg_pkg::DRV0_RST);
    chk("irq", {7'h00, irq_q}, 8'h00);
    rd(pscfg_pkg::OFS_IRQ_EN, d);
    chk("irq_en", d, 8'h00);
  endtask
  // One status flag at a time; a write to the read-only word must not stick
  task automatic t_status();
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      st <= (i < 6) ? (6'h01 << i) : 6'h00;
      repeat (3) @(posedge clk);
      wr(pscfg_pkg::OFS_STATUS, 8'hFF);
      rd(pscfg_pkg::OFS_STATUS, d);
      chk("status", d, (i < 6) ? (8'h01 << i) : 8'h00);
    end
    // The walk above makes every one of the six event kinds at least once
    rd(pscfg_pkg::OFS_IRQ_STAT, d);
    chk("irq_stat", d, 8'h3F);
  endtask
  task automatic t_drv();
    logic [7:0] cfg [11] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h80, 8'hA0, 8'hC0, 8'hE0,
                             8'hE8, 8'hF0, 8'hF8};
    foreach (cfg[i]) begin
      wr_rd(pscfg_pkg::OFS_DRV0, cfg[i], d);
      chk("leg", {3'h0, leg_q}, dec(cfg[i]));
      chk("drv", d, cfg[i]);
    end
    wr(pscfg_pkg::OFS_DRV0, pscfg_pkg::DRV0_RST);
  endtask
  // Lock event raises the interrupt, then mask, unmask and clear
  task automatic t_irq();
    int k;
    repeat (4) @(posedge clk);
    wr(pscfg_pkg::OFS_IRQ_CLR, 8'h3F);
    wr(pscfg_pkg::OFS_IRQ_EN, 8'h01);
    chk("irq", {7'h00, irq_q}, 8'h00);
    @(posedge clk);
    st <= 6'h01;
    for (k = 0; k < 8 && irq_q !== 1'h1; k++) begin
      @(posedge clk);
      #1;
    end
    if (irq_q !== 1'h1) begin
      n_fail++;
      final_report();
    end
    rd(pscfg_pkg::OFS_IRQ_STAT, d);
    chk("irq_stat", d, 8'h01);
    wr(pscfg_pkg::OFS_IRQ_EN, 8'h00);
    chk("irq", {7'h00, irq_q}, 8'h00);
    wr(pscfg_pkg::OFS_IRQ_EN, 8'h01);
    chk("irq", {7'h00, irq_q}, 8'h01);
    wr(pscfg_pkg::OFS_IRQ_CLR, 8'h01);
    rd(pscfg_pkg::OFS_IRQ_STAT, d);
    chk("irq_stat", d, 8'h00);
    chk("irq", {7'h00, irq_q}, 8'h00);
    rd(10'h3FF, d);
    chk("unmapped", d, 8'h00);
    rd(pscfg_pkg::OFS_IRQ_CLR, d);
    chk("irq_clr", d, 8'h00);
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    #1;
    t_reset();
    t_status();
    t_drv();
    t_irq();
    final_report();
  end
  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    final_report();
  end
endmodule

bind pscfg_top pscfg_chk u_pscfg_chk (.clk(clk), .arst_n(arst_n), .bus(bus),
  .rd_data_q(rd_data_q), .holdover_active(holdover_active), .second_reference_input_selected(second_reference_input_selected),
  .vco_above_thresh(vco_above_thresh), .second_reference_input_above_thresh(second_reference_input_above_thresh),
  .first_reference_input_above_thresh(first_reference_input_above_thresh), .lock_detect(lock_detect), .leg_q(leg_q),
  .irq_q(irq_q));

`default_nettype wire
